// ==== rtl/srcc_mux4.sv ====
module srcc_mux4 #(
    parameter int W = 1
) (
    // Select
    input wire logic [1:0] sel,
    // Data inputs
    input wire logic [W-1:0] d0,
    input wire logic [W-1:0] d1,
    input wire logic [W-1:0] d2,
    input wire logic [W-1:0] d3,
    // Output
    output logic [W-1:0] y
);

    // Strobe tied active: output always follows the selected input
    always_comb begin
        case (sel)
            2'd0: y = d0;
            2'd1: y = d1;
            2'd2: y = d2;
            2'd3: y = d3;
            default: y = d0;
        endcase
    end

endmodule

// ==== rtl/srcc_pkg.sv ====
package srcc_pkg;

    // =====================================================================
    // Register map (byte addresses, one aligned word each)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_B_HOLDING_REGISTER = 8'h00;
    localparam logic [7:0] OFS_B_LEG_BUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_CWORD = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STEP = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // =====================================================================
    // Field positions
    localparam int CW_SEL_HI = 28;
    localparam int CW_SEL_LO = 29;
    localparam int CW_AUX = 24;
    localparam int CTRL_BYTE = 0;
    localparam int CTRL_ROT = 1;
    localparam int CTRL_NEG = 2;
    localparam int CTRL_LSIGN = 3;
    localparam int CTRL_ALU_C = 4;
    localparam int CTRL_ALU_V = 5;
    localparam int CTRL_CC_EN = 6;
    localparam int CTRL_W = 7;
    localparam int STEP_GO = 0;
    localparam int ST_NEXT = 4;
    localparam int ST_SIN = 8;
    localparam int ST_SOUT = 9;
    localparam int ST_ZDEN = 10;
    localparam int PSW_N = 3;
    localparam int PSW_Z = 2;
    localparam int PSW_V = 1;
    localparam int PSW_C = 0;
    localparam int MSB = 15;
    localparam int LSB = 0;
    localparam int BYTE_MSB = 7;

    // =====================================================================
    // Values
    localparam logic [15:0] NEG_OVF_VAL = 16'h8000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_CW = 32'h0000_0000;
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {SH_ROR, SH_ASR, SH_ROL, SH_ASL} srcc_shift_e;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } srcc_flags_s;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } srcc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } srcc_axi_rsp_s;

endpackage

// ==== rtl/srcc_top.sv ====
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module srcc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire srcc_pkg::srcc_axi_req_s axi_req,
    output srcc_pkg::srcc_axi_rsp_s axi_rsp,
    // Condition codes
    output logic [3:0] cc_flags
);

    // =====================================================================
    // Register file state
    logic [15:0] b_holding_register_ff;
    logic [15:0] b_leg_bus_ff;
    logic [15:0] a_input_selector_ff;
    logic [31:0] cword_ff;
    logic [srcc_pkg::CTRL_W-1:0] ctrl_ff;
    logic step_ff;
    srcc_pkg::srcc_flags_s cc_ff;

    logic aw_got_ff, w_got_ff;
    logic [srcc_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // =====================================================================
    // Shift selectors
    logic [1:0] shift_sel;
    logic is_byte, rotate_category, negate_op, left_shift_sign, aux_load;
    logic serial_shift_in_bit, shift_negative_source, shift_carry_out, zd_enable;

    assign shift_sel = {cword_ff[srcc_pkg::CW_SEL_HI], cword_ff[srcc_pkg::CW_SEL_LO]};
    assign is_byte = ctrl_ff[srcc_pkg::CTRL_BYTE];
    assign rotate_category = ctrl_ff[srcc_pkg::CTRL_ROT];
    assign negate_op = ctrl_ff[srcc_pkg::CTRL_NEG];
    assign left_shift_sign = ctrl_ff[srcc_pkg::CTRL_LSIGN];
    assign aux_load = cword_ff[srcc_pkg::CW_AUX];

    // Inputs ordered ROTATE_RIGHT_OP, ARITH_SHIFT_RIGHT, ROTATE_LEFT_OP, ARITH_SHIFT_LEFT to match the select code
    srcc_mux4 #(.W(1)) u_shift_in_selector (
        .sel(shift_sel), .d0(cc_ff.c), .d1(b_holding_register_ff[srcc_pkg::MSB]),
        .d2(cc_ff.c), .d3(1'b0), .y(serial_shift_in_bit)
    );

    srcc_mux4 #(.W(1)) u_shift_neg_selector (
        .sel(shift_sel), .d0(cc_ff.c), .d1(b_holding_register_ff[srcc_pkg::MSB]),
        .d2(left_shift_sign), .d3(left_shift_sign), .y(shift_negative_source)
    );

    srcc_mux4 #(.W(1)) u_shift_out_selector (
        .sel(shift_sel), .d0(b_holding_register_ff[srcc_pkg::LSB]),
        .d1(b_holding_register_ff[srcc_pkg::LSB]), .d2(b_holding_register_ff[srcc_pkg::MSB]),
        .d3(b_holding_register_ff[srcc_pkg::MSB]), .y(shift_carry_out)
    );

    srcc_mux4 #(.W(1)) u_zero_enable_selector (
        .sel(shift_sel), .d0(b_leg_bus_ff[srcc_pkg::MSB] & cc_ff.c),
        .d1(~b_leg_bus_ff[srcc_pkg::MSB]), .d2(b_leg_bus_ff[srcc_pkg::LSB] & cc_ff.c),
        .d3(~b_leg_bus_ff[srcc_pkg::LSB]), .y(zd_enable)
    );

    // =====================================================================
    // Negative and zero source selection
    logic [1:0] nz_word, nz_rot, nz_byte, nz_rotbyte, nz_sel;
    logic negative_flag_next, zero_flag_next;

    assign nz_word = {a_input_selector_ff[srcc_pkg::MSB],
                      a_input_selector_ff == srcc_pkg::RST_WORD};
    // Gated detector reads zero while its enable is low
    assign nz_rot = {shift_negative_source,
                     zd_enable & (b_leg_bus_ff[14:1] == 14'h0000)};
    assign nz_byte = {a_input_selector_ff[srcc_pkg::BYTE_MSB],
                      a_input_selector_ff[7:0] == 8'h00};
    assign nz_rotbyte = {shift_negative_source, zd_enable & (b_leg_bus_ff[6:1] == 6'h00)};

    srcc_mux4 #(.W(2)) u_neg_zero_source_selector (
        .sel({is_byte, rotate_category}), .d0(nz_word), .d1(nz_rot),
        .d2(nz_byte), .d3(nz_rotbyte), .y(nz_sel)
    );
    assign negative_flag_next = nz_sel[1];
    assign zero_flag_next = nz_sel[0];

    // =====================================================================
    // Carry and overflow
    logic carry_flag_next;
    logic overflow_flag_next;

    // Lookup inputs ignored while rotating, so shifts never see ALU carry
    always_comb begin
        if (rotate_category) begin
            carry_flag_next = shift_carry_out;
            overflow_flag_next = negative_flag_next ^ shift_carry_out;
        end else if (negate_op) begin
            carry_flag_next = a_input_selector_ff != srcc_pkg::RST_WORD;
            overflow_flag_next = a_input_selector_ff == srcc_pkg::NEG_OVF_VAL;
        end else begin
            carry_flag_next = ctrl_ff[srcc_pkg::CTRL_ALU_C];
            overflow_flag_next = ctrl_ff[srcc_pkg::CTRL_ALU_V];
        end
    end

    // =====================================================================
    // Flag load selector and condition-code flip-flops
    srcc_pkg::srcc_flags_s flags_computed;
    srcc_pkg::srcc_flags_s nxt_cc;
    logic cc_load;

    assign flags_computed = '{n: negative_flag_next, z: zero_flag_next,
                              v: overflow_flag_next, c: carry_flag_next};
    assign nxt_cc = aux_load ? srcc_pkg::srcc_flags_s'(a_input_selector_ff[3:0])
                             : flags_computed;
    assign cc_load = step_ff & ctrl_ff[srcc_pkg::CTRL_CC_EN];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cc_ff <= srcc_pkg::RST_FLAGS;
        end else if (cc_load) begin
            cc_ff <= nxt_cc;
        end
    end

    assign cc_flags = cc_ff;

    // =====================================================================
    // Write channel
    logic wr_fire;
    logic wr_map;

    assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign wr_map = awaddr_ff == srcc_pkg::OFS_B_HOLDING_REGISTER || awaddr_ff == srcc_pkg::OFS_B_LEG_BUS ||
                    awaddr_ff == srcc_pkg::OFS_RESULT || awaddr_ff == srcc_pkg::OFS_CWORD ||
                    awaddr_ff == srcc_pkg::OFS_CTRL || awaddr_ff == srcc_pkg::OFS_STEP;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (axi_req.awvalid && axi_rsp.awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= axi_req.awaddr;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_got_ff <= 1'b0;
            wdata_ff <= srcc_pkg::RST_CW;
            wstrb_ff <= 4'h0;
        end else if (axi_req.wvalid && axi_rsp.wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= axi_req.wdata;
            wstrb_ff <= axi_req.wstrb;
        end else if (wr_fire) begin
            w_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= srcc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? srcc_pkg::RESP_OKAY : srcc_pkg::RESP_SLVERR;
        end else if (axi_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            b_holding_register_ff <= srcc_pkg::RST_WORD;
            b_leg_bus_ff <= srcc_pkg::RST_WORD;
            a_input_selector_ff <= srcc_pkg::RST_WORD;
            cword_ff <= srcc_pkg::RST_CW;
            ctrl_ff <= srcc_pkg::RST_CTRL;
        end else if (wr_fire) begin
            case (awaddr_ff)
                srcc_pkg::OFS_B_HOLDING_REGISTER: b_holding_register_ff <=
                    16'(merge({16'h0000, b_holding_register_ff}, wdata_ff, wstrb_ff));
                srcc_pkg::OFS_B_LEG_BUS: b_leg_bus_ff <=
                    16'(merge({16'h0000, b_leg_bus_ff}, wdata_ff, wstrb_ff));
                srcc_pkg::OFS_RESULT: a_input_selector_ff <=
                    16'(merge({16'h0000, a_input_selector_ff}, wdata_ff, wstrb_ff));
                srcc_pkg::OFS_CWORD: cword_ff <= merge(cword_ff, wdata_ff, wstrb_ff);
                srcc_pkg::OFS_CTRL: ctrl_ff <= srcc_pkg::CTRL_W'(merge({25'h000_0000, ctrl_ff},
                                                                        wdata_ff, wstrb_ff));
                default: ;
            endcase
        end
    end

    // One-cycle step pulse; flags captured while it is high and CTRL_CC_EN is set
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_ff <= 1'b0;
        end else begin
            step_ff <= wr_fire && awaddr_ff == srcc_pkg::OFS_STEP && wstrb_ff[0] &&
                       wdata_ff[srcc_pkg::STEP_GO];
        end
    end

    // =====================================================================
    // Read channel
    logic [31:0] rd_word;
    logic rd_map;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_map = 1'b1;
        case (axi_req.araddr)
            srcc_pkg::OFS_B_HOLDING_REGISTER: rd_word[15:0] = b_holding_register_ff;
            srcc_pkg::OFS_B_LEG_BUS: rd_word[15:0] = b_leg_bus_ff;
            srcc_pkg::OFS_RESULT: rd_word[15:0] = a_input_selector_ff;
            srcc_pkg::OFS_CWORD: rd_word = cword_ff;
            srcc_pkg::OFS_CTRL: rd_word[srcc_pkg::CTRL_W-1:0] = ctrl_ff;
            srcc_pkg::OFS_STEP: rd_word = 32'h0000_0000;
            srcc_pkg::OFS_STATUS: begin
                rd_word[3:0] = cc_ff;
                rd_word[srcc_pkg::ST_NEXT +: 4] = nxt_cc;
                rd_word[srcc_pkg::ST_SIN] = serial_shift_in_bit;
                rd_word[srcc_pkg::ST_SOUT] = shift_carry_out;
                rd_word[srcc_pkg::ST_ZDEN] = zd_enable;
            end
            default: rd_map = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= srcc_pkg::RESP_OKAY;
        end else if (axi_req.arvalid && axi_rsp.arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_map ? srcc_pkg::RESP_OKAY : srcc_pkg::RESP_SLVERR;
        end else if (axi_req.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Ready held low while a captured beat waits, so nothing is overwritten
    assign axi_rsp.awready = ~aw_got_ff & ~bvalid_ff;
    assign axi_rsp.wready = ~w_got_ff & ~bvalid_ff;
    assign axi_rsp.bvalid = bvalid_ff;
    assign axi_rsp.bresp = bresp_ff;
    assign axi_rsp.arready = ~rvalid_ff;
    assign axi_rsp.rvalid = rvalid_ff;
    assign axi_rsp.rdata = rdata_ff;
    assign axi_rsp.rresp = rresp_ff;

    // =====================================================================
    // Checks
    logic cap_computed;
    assign cap_computed = cc_load & ~aux_load;

    chk_shift_in_asl: assert property (@(posedge ref_clk) disable iff (sys_rst)
        shift_sel == srcc_pkg::SH_ASL |-> !serial_shift_in_bit)
        else $error("shift-in bit not zero for left shift");
    chk_carry_out_dir: assert property (@(posedge ref_clk) disable iff (sys_rst)
        shift_carry_out == (shift_sel[1] ? b_holding_register_ff[15] : b_holding_register_ff[0]))
        else $error("shift carry out from wrong end");
    chk_neg_overflow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && !rotate_category && negate_op |=>
        cc_ff.v == ($past(a_input_selector_ff) == 16'h8000) &&
        cc_ff.c == ($past(a_input_selector_ff) != 16'h0000))
        else $error("negate carry or overflow wrong");
    chk_asr_carry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && rotate_category && shift_sel == srcc_pkg::SH_ASR |=>
        cc_ff.c == $past(b_holding_register_ff[0]))
        else $error("right shift carry not from bit 0");
    chk_asr_ovf_xor: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && rotate_category |=> cc_ff.v == (cc_ff.n ^ cc_ff.c))
        else $error("shift overflow not n xor c");
    chk_word_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && !rotate_category && !is_byte |=>
        cc_ff.z == ($past(a_input_selector_ff) == 16'h0000) &&
        cc_ff.n == $past(a_input_selector_ff[15]))
        else $error("word zero or negative flag wrong");
    chk_shift_zero_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && rotate_category && !zd_enable |=> !cc_ff.z)
        else $error("shift zero set without enable");
    chk_flags_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !cc_load |=> $stable(cc_ff))
        else $error("flags changed without update");
    chk_write_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
        aw_got_ff && w_got_ff && !bvalid_ff |=> bvalid_ff)
        else $error("write response missing");
    cov_asr_step: cover property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && rotate_category && shift_sel == srcc_pkg::SH_ASR);
    cov_neg_ovf: cover property (@(posedge ref_clk) disable iff (sys_rst)
        cap_computed && negate_op && a_input_selector_ff == 16'h8000);
    cov_aux_load: cover property (@(posedge ref_clk) disable iff (sys_rst) cc_load && aux_load);

endmodule

// ==== verif/srcc_axi_host.sv ====
// =====================================================================
// Bus master standing in for the microcode and data path side
module srcc_axi_host (
    // Clock
    input wire logic ref_clk,
    // Register bus
    output srcc_pkg::srcc_axi_req_s req,
    input wire srcc_pkg::srcc_axi_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // =====================================================================
    // Write: address and data offered together, each dropped when taken
    // Handshakes are judged mid-cycle, when inputs and readies have settled
    task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                      output logic [1:0] resp);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        b_hs = 1'b0;
        @(posedge ref_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= addr;
        req.wvalid <= 1'b1;
        req.wdata <= data;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (b_hs !== 1'b1) begin
            @(negedge ref_clk);
            aw_hs = req.awvalid && rsp.awready;
            w_hs = req.wvalid && rsp.wready;
            b_hs = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge ref_clk);
            if (aw_hs) begin
                req.awvalid <= 1'b0;
            end
            if (w_hs) begin
                req.wvalid <= 1'b0;
            end
        end
        req.bready <= 1'b0;
    endtask

    // =====================================================================
    // Read: rready held from the start until rvalid is seen
    task automatic rd(input logic [7:0] addr, output logic [31:0] data,
                      output logic [1:0] resp);
        logic ar_hs;
        logic r_hs;
        r_hs = 1'b0;
        @(posedge ref_clk);
        req.arvalid <= 1'b1;
        req.araddr <= addr;
        req.rready <= 1'b1;
        while (r_hs !== 1'b1) begin
            @(negedge ref_clk);
            ar_hs = req.arvalid && rsp.arready;
            r_hs = rsp.rvalid;
            data = rsp.rdata;
            resp = rsp.rresp;
            @(posedge ref_clk);
            if (ar_hs) begin
                req.arvalid <= 1'b0;
            end
        end
        req.rready <= 1'b0;
    endtask
endmodule

// ==== verif/test_shift_rotate_condition_codes.sv ====
module test_shift_rotate_condition_codes;
    timeunit 1ns;
    timeprecision 1ps;

    // Mode = {rotate, negate, lsign, lookup C, lookup V, held carry}
    // Expect = {zden, shift out, shift in, N, Z, V, C}
    typedef struct packed {
        logic [1:0] sel;
        logic [5:0] mode;
        logic [15:0] b_holding_register;
        logic [15:0] b_leg_bus;
        logic [15:0] res;
        logic [6:0] expect_v;
    } srcc_row_s;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    srcc_pkg::srcc_axi_req_s axi_req;
    srcc_pkg::srcc_axi_rsp_s axi_rsp;
    logic [3:0] cc_flags;
    logic [31:0] rdata;
    logic [1:0] resp;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    srcc_row_s rows [15];
    srcc_row_s r;

    always #2.5 ref_clk = ~ref_clk;

    srcc_top i_srcc_top (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .cc_flags(cc_flags)
    );

    srcc_axi_host i_srcc_axi_host (
        .ref_clk(ref_clk),
        .req(axi_req),
        .rsp(axi_rsp)
    );

    // =====================================================================
    // Reporting
    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // Hang guard: whole run needs under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // =====================================================================
    // Bus helpers
    task automatic w(input logic [7:0] addr, input logic [31:0] data);
        i_srcc_axi_host.wr(addr, data, resp);
        chk("bresp", {14'h0000, srcc_pkg::RESP_OKAY}, {14'h0000, resp});
    endtask

    // Flag capture lands two edges after the write fires
    task automatic step();
        w(srcc_pkg::OFS_STEP, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
    endtask

    // Raw flag load through the aux path, so held carry is known
    task automatic preload(input logic [3:0] f);
        w(srcc_pkg::OFS_CTRL, 32'h0000_0040);
        w(srcc_pkg::OFS_RESULT, {28'h000_0000, f});
        w(srcc_pkg::OFS_CWORD, 32'h0100_0000);
        step();
        chk("preload", {12'h000, f}, {12'h000, cc_flags}); // Flag bit order
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        rows = '{
            '{2'h1, 6'h26, 16'h8001, 16'h0000, 16'h0000, 7'h7d},
            '{2'h1, 6'h26, 16'h0002, 16'h8000, 16'h0000, 7'h00},
            '{2'h1, 6'h20, 16'h0001, 16'h0002, 16'h0000, 7'h63},
            '{2'h3, 6'h28, 16'h8000, 16'h0000, 16'h0000, 7'h6d},
            '{2'h3, 6'h21, 16'h7fff, 16'h0001, 16'h0000, 7'h00},
            '{2'h2, 6'h29, 16'h0000, 16'h0001, 16'h0000, 7'h5e},
            '{2'h2, 6'h20, 16'hffff, 16'h0001, 16'h0000, 7'h23},
            '{2'h0, 6'h21, 16'h0001, 16'h8000, 16'h0000, 7'h7d},
            '{2'h0, 6'h20, 16'hfffe, 16'h8000, 16'h0000, 7'h00},
            '{2'h3, 6'h16, 16'h8000, 16'h0001, 16'h0000, 7'h24},
            '{2'h0, 6'h11, 16'h0000, 16'h0000, 16'h8000, 7'h1b},
            '{2'h1, 6'h10, 16'h8000, 16'h0000, 16'h0200, 7'h51},
            '{2'h2, 6'h02, 16'h0000, 16'h0000, 16'h8000, 7'h0a},
            '{2'h0, 6'h04, 16'h0000, 16'h0000, 16'h0000, 7'h05},
            '{2'h0, 6'h00, 16'h0000, 16'h0000, 16'h0001, 7'h00}
        };
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk("cc_flags after reset", 16'h0000, {12'h000, cc_flags}); // Cleared
        i_srcc_axi_host.rd(srcc_pkg::OFS_STATUS, rdata, resp);
        chk("status after reset", 16'h0040, rdata[15:0]); // Zero word

        for (int i = 0; i < 15; i++) begin
            r = rows[i];
            preload({3'h0, r.mode[0]});
            w(srcc_pkg::OFS_B_HOLDING_REGISTER, {16'h0000, r.b_holding_register});
            w(srcc_pkg::OFS_B_LEG_BUS, {16'h0000, r.b_leg_bus});
            w(srcc_pkg::OFS_RESULT, {16'h0000, r.res});
            w(srcc_pkg::OFS_CWORD, {2'h0, r.sel[0], r.sel[1], 28'h000_0000});
            w(srcc_pkg::OFS_CTRL, {25'h000_0000, 1'b1, r.mode[1], r.mode[2], r.mode[3],
                                   r.mode[4], r.mode[5], 1'b0});
            i_srcc_axi_host.rd(srcc_pkg::OFS_STATUS, rdata, resp);
            chk("next flags and shift bits", {9'h000, r.expect_v}, {9'h000, rdata[10:4]}); // Selectors
            step();
            chk("cc_flags", {12'h000, r.expect_v[3:0]}, {12'h000, cc_flags}); // Loaded
        end

        // Byte categories: low-byte result, then the narrow rotate zero detector
        w(srcc_pkg::OFS_RESULT, 32'h0000_8100);
        w(srcc_pkg::OFS_CTRL, 32'h0000_0001);
        i_srcc_axi_host.rd(srcc_pkg::OFS_STATUS, rdata, resp);
        chk("byte next flags", 16'h0004, {12'h000, rdata[7:4]}); // Byte N/Z
        w(srcc_pkg::OFS_B_LEG_BUS, 32'h0000_0100);
        w(srcc_pkg::OFS_CWORD, 32'h3000_0000);
        w(srcc_pkg::OFS_CTRL, 32'h0000_004b);
        i_srcc_axi_host.rd(srcc_pkg::OFS_STATUS, rdata, resp);
        chk("rotate byte status", 16'h04e0, {5'h00, rdata[10:0]});
        step();
        chk("rotate byte cc_flags", 16'h000e, {12'h000, cc_flags});

        // Update enable low: flags must hold through a step
        preload(4'hf);
        w(srcc_pkg::OFS_CTRL, 32'h0000_0002);
        step();
        chk("cc_flags held", 16'h000f, {12'h000, cc_flags}); // No capture

        // Unmapped places and write-only step register
        i_srcc_axi_host.rd(8'h40, rdata, resp);
        chk("unmapped rresp", {14'h0000, srcc_pkg::RESP_SLVERR}, {14'h0000, resp});
        chk("unmapped rdata", 16'h0000, rdata[15:0]);
        i_srcc_axi_host.wr(8'h40, 32'h0000_ffff, resp);
        chk("unmapped bresp", {14'h0000, srcc_pkg::RESP_SLVERR}, {14'h0000, resp});
        i_srcc_axi_host.rd(srcc_pkg::OFS_STEP, rdata, resp);
        chk("step reads zero", 16'h0000, rdata[15:0]);

        // Reset in mid-run clears held flags
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(negedge ref_clk);
        chk("cc_flags mid reset", 16'h0000, {12'h000, cc_flags}); // Cleared
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        i_srcc_axi_host.rd(srcc_pkg::OFS_STATUS, rdata, resp);
        chk("status after mid reset", 16'h0040, rdata[15:0]); // Zero word
        close_out();
    end
endmodule
